// *** src/ispb_pkg.sv ***
// Shared constants for the interrupt state and priority bank.
package ispb_pkg;

    // ------------------------------------------------------------------
    // Sizing
    // ------------------------------------------------------------------
    localparam int NUM_IRQ    = 64;
    localparam int NUM_WORDS  = NUM_IRQ / 32;
    localparam int PRIO_WORDS = NUM_IRQ / 4;
    localparam int PRIO_BITS  = 3;
    localparam int ADR_W      = 12;
    localparam int ID_W       = 6;

    // Security option present in this build.
    localparam logic SEC_IMPL = 1'b1;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADR_W-1:0] REG_CTRL     = 12'h000;
    localparam logic [ADR_W-1:0] REG_EN_SET   = 12'h100;
    localparam logic [ADR_W-1:0] REG_EN_CLR   = 12'h180;
    localparam logic [ADR_W-1:0] REG_PEND_SET = 12'h200;
    localparam logic [ADR_W-1:0] REG_PEND_CLR = 12'h280;
    localparam logic [ADR_W-1:0] REG_ACTIVE   = 12'h300;
    localparam logic [ADR_W-1:0] REG_TARGET   = 12'h380;
    localparam logic [ADR_W-1:0] REG_PRIO     = 12'h400;
    localparam logic [ADR_W-1:0] REG_PRIO_END = 12'h5dc;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int              CTRL_NONSECURE_PRIORITY_SHIFT_BIT = 0;
    localparam logic [7:0]      PRIO_MASK     = 8'(8'hff << (8 - PRIO_BITS));
    localparam logic [7:0]      NS_PRIO_BASE  = 8'h80;
    localparam logic [NUM_IRQ-1:0] IRQ_ARR_RST = 64'h0;
    localparam logic [31:0]     WORD_RST      = 32'h0;
    localparam logic [ID_W-1:0] LAST_IRQ      = 6'h3f;

endpackage

// *** src/ispb_prio_if.sv ***
// Connection between the bank logic and its priority store.
`timescale 1ns/100ps
`default_nettype none
interface ispb_prio_if;
    logic        wr_en;
    logic [3:0]  wr_word;
    logic [3:0]  wr_be;
    logic [31:0] wr_data;
    logic [3:0]  ra_word;
    logic [31:0] ra_data;
    logic [3:0]  rb_word;
    logic [31:0] rb_data;

    modport mem (
        input  wr_en, wr_word, wr_be, wr_data, ra_word, rb_word,
        output ra_data, rb_data
    );
    modport ctl (
        output wr_en, wr_word, wr_be, wr_data, ra_word, rb_word,
        input  ra_data, rb_data
    );
endinterface
`default_nettype wire

// *** src/ispb_prio_mem.sv ***
// Priority store: byte-writable words with two registered read ports.
`timescale 1ns/100ps
`default_nettype none
module ispb_prio_mem
    import ispb_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   srst,
    // Store access
    ispb_prio_if.mem    port
);

    typedef struct packed {
        logic [PRIO_WORDS-1:0][31:0] words;
        logic [31:0]                 ra;
        logic [31:0]                 rb;
    } ispb_mem_state_t;

    ispb_mem_state_t q;
    ispb_mem_state_t d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        for (int l = 0; l < 4; l++) begin
            if (port.wr_en && port.wr_be[l]) begin
                d.words[port.wr_word][8*l +: 8] = port.wr_data[8*l +: 8] & PRIO_MASK;
            end
        end
        d.ra = q.words[port.ra_word];
        d.rb = q.words[port.rb_word];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign port.ra_data = q.ra;
    assign port.rb_data = q.rb;

endmodule
`default_nettype wire

// *** src/ispb_bank.sv ***
// Interrupt state and priority bank with a Wishbone register slave.
`timescale 1ns/100ps
`default_nettype none
module ispb_bank
    import ispb_pkg::*;
(
    // Clock and reset
    input  wire logic               CLOCK_IN,
    input  wire logic               SRST_IN,
    // Wishbone slave
    input  wire logic               WB_CYC_IN,
    input  wire logic               WB_STB_IN,
    input  wire logic               WB_WE_IN,
    input  wire logic [ADR_W-1:0]   WB_ADR_IN,
    input  wire logic [3:0]         WB_SEL_IN,
    input  wire logic [31:0]        WB_DAT_IN,
    input  wire logic               WB_NONSEC_IN,
    output logic                    WB_ACK_OUT,
    output logic [31:0]             WB_DAT_OUT,
    // Peripheral request lines
    input  wire logic [NUM_IRQ-1:0] IRQ_LINES_IN,
    // Processor core
    input  wire logic               TAKE_IN,
    input  wire logic [ID_W-1:0]    TAKE_ID_IN,
    input  wire logic               DONE_IN,
    input  wire logic [ID_W-1:0]    DONE_ID_IN,
    output logic                    IRQ_REQ_OUT,
    output logic [ID_W-1:0]         IRQ_ID_OUT,
    output logic [7:0]              IRQ_PRIO_OUT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_IRQ-1:0] enable;
        logic [NUM_IRQ-1:0] pending;
        logic [NUM_IRQ-1:0] active;
        logic [NUM_IRQ-1:0] target;
        logic               nonsecure_priority_shift;
        logic               busy;
        logic               ack;
        logic [31:0]        rdata;
        logic [ID_W-1:0]    scan_idx;
        logic [ID_W-1:0]    eval_idx;
        logic               eval_vld;
        logic               best_vld;
        logic [ID_W-1:0]    best_id;
        logic [7:0]         best_prio;
        logic               req;
        logic [ID_W-1:0]    req_id;
        logic [7:0]         req_prio;
    } ispb_state_t;

    ispb_state_t q;
    ispb_state_t d;

    ispb_prio_if pif ();

    ispb_prio_mem u_prio_mem (
        .clk  (CLOCK_IN),
        .srst (SRST_IN),
        .port (pif)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Expands four byte flags into a 32-bit bit mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] lanes);
        lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    endfunction

    // True when the address falls in the 16-word group starting at base.
    function automatic logic in_group(input logic [ADR_W-1:0] adr,
                                      input logic [ADR_W-1:0] base);
        in_group = (adr[ADR_W-1:6] == base[ADR_W-1:6]);
    endfunction

    // Reads 32-bit word n of a per-interrupt array; absent words are zero.
    function automatic logic [31:0] word_get(input logic [NUM_IRQ-1:0] arr,
                                             input logic [3:0]         n);
        word_get = WORD_RST;
        if (32'(n) < NUM_WORDS) begin
            word_get = arr[32*n[0] +: 32];
        end
    endfunction

    // Places a 32-bit mask at word n of a per-interrupt array.
    function automatic logic [NUM_IRQ-1:0] word_put(input logic [31:0] bits,
                                                    input logic [3:0]  n);
        word_put = IRQ_ARR_RST;
        if (32'(n) < NUM_WORDS) begin
            word_put[32*n[0] +: 32] = bits;
        end
    endfunction

    // Priority seen by the arbiter after the non-secure shift.
    function automatic logic [7:0] eff_prio(input logic [7:0] p,
                                            input logic       ns,
                                            input logic       shift);
        eff_prio = (ns && shift) ? (NS_PRIO_BASE | {1'b0, p[7:1]}) : p;
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic                   req_go;
    logic                   nonsec;
    logic [3:0]             grp_word;
    logic [ADR_W-1:0]       prio_off;
    logic [6:0]             prio_idx;
    logic                   hit_ctrl;
    logic                   hit_en_set;
    logic                   hit_en_clr;
    logic                   hit_pend_set;
    logic                   hit_pend_clr;
    logic                   hit_active;
    logic                   hit_target;
    logic                   hit_prio;
    logic                   prio_in_range;
    logic [NUM_IRQ-1:0]     vis;
    logic [3:0]             lane_vis;
    logic [31:0]            wmask;
    logic [NUM_IRQ-1:0]     wbits;
    logic                   wr_now;

    always_comb begin
        req_go        = WB_CYC_IN && WB_STB_IN && !q.busy && !q.ack;
        nonsec        = SEC_IMPL && WB_NONSEC_IN;
        grp_word      = WB_ADR_IN[5:2];
        prio_off      = WB_ADR_IN - REG_PRIO;
        prio_idx      = prio_off[8:2];
        hit_ctrl      = (WB_ADR_IN[ADR_W-1:2] == REG_CTRL[ADR_W-1:2]);
        hit_en_set    = in_group(WB_ADR_IN, REG_EN_SET);
        hit_en_clr    = in_group(WB_ADR_IN, REG_EN_CLR);
        hit_pend_set  = in_group(WB_ADR_IN, REG_PEND_SET);
        hit_pend_clr  = in_group(WB_ADR_IN, REG_PEND_CLR);
        hit_active    = in_group(WB_ADR_IN, REG_ACTIVE);
        hit_target    = in_group(WB_ADR_IN, REG_TARGET);
        hit_prio      = (WB_ADR_IN >= REG_PRIO) && (WB_ADR_IN <= REG_PRIO_END);
        prio_in_range = hit_prio && (32'(prio_idx) < PRIO_WORDS);
        // Non-secure callers only see interrupts aimed at non-secure state.
        vis           = nonsec ? q.target : ~IRQ_ARR_RST;
        lane_vis      = vis[4*prio_idx[3:0] +: 4];
        wmask         = WB_DAT_IN & lane_mask(WB_SEL_IN);
        wbits         = word_put(wmask, grp_word) & vis;
        wr_now        = q.busy && WB_WE_IN;
    end

    // ------------------------------------------------------------------
    // Priority store ports
    // ------------------------------------------------------------------
    assign pif.ra_word = prio_idx[3:0];
    assign pif.wr_en   = wr_now && prio_in_range;
    assign pif.wr_word = prio_idx[3:0];
    assign pif.wr_be   = WB_SEL_IN & lane_vis;
    assign pif.wr_data = WB_DAT_IN;
    assign pif.rb_word = q.scan_idx[ID_W-1:2];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic               take_hit;
    logic [NUM_IRQ-1:0] act_n;
    logic [NUM_IRQ-1:0] pend_n;
    logic [7:0]         cand_raw;
    logic [7:0]         cand_eff;
    logic               cand_ok;
    logic               b_vld;
    logic [ID_W-1:0]    b_id;
    logic [7:0]         b_prio;

    always_comb begin
        d        = q;
        act_n    = q.active;
        pend_n   = q.pending;
        cand_raw = 8'h00;
        cand_eff = 8'h00;
        cand_ok  = 1'b0;
        b_vld    = q.best_vld;
        b_id     = q.best_id;
        b_prio   = q.best_prio;
        take_hit = TAKE_IN && q.req && (TAKE_ID_IN == q.req_id);

        // ------------------------------------------------------------------
        // Bus handshake
        // ------------------------------------------------------------------
        // A request is taken, worked on for one cycle, then acknowledged for
        // one cycle. No new request is taken during the work or ack cycle,
        // so a request still held in its ack cycle does not act twice; one held past it acts again.
        d.busy = req_go;
        d.ack  = q.busy;

        // ------------------------------------------------------------------
        // State arrays
        // ------------------------------------------------------------------
        // Enable array, set and clear views share one copy.
        if (wr_now && hit_en_set) begin
            d.enable = q.enable | wbits;
        end
        if (wr_now && hit_en_clr) begin
            d.enable = q.enable & ~wbits;
        end

        // Active: core entry sets it, core exit clears it.
        if (DONE_IN) begin
            act_n[DONE_ID_IN] = 1'b0;
        end
        if (TAKE_IN) begin
            act_n[TAKE_ID_IN] = 1'b1;
        end
        d.active = act_n;

        // Pending: software and entry clears first, then sets win; a line sets only an interrupt that is not active.
        if (wr_now && hit_pend_clr) begin
            pend_n = pend_n & ~wbits;
        end
        if (TAKE_IN) begin
            pend_n[TAKE_ID_IN] = 1'b0;
        end
        if (wr_now && hit_pend_set) begin
            pend_n = pend_n | wbits;
        end
        // A line pends its interrupt whether or not it is enabled.
        pend_n  = pend_n | (IRQ_LINES_IN & ~act_n);
        d.pending = pend_n;

        // Target bits and shift control: secure writers only.
        if (wr_now && hit_target && SEC_IMPL && !nonsec) begin
            d.target = (q.target & ~word_put(lane_mask(WB_SEL_IN), grp_word))
                     | word_put(wmask, grp_word);
        end
        if (wr_now && hit_ctrl && SEC_IMPL && !nonsec && WB_SEL_IN[0]) begin
            d.nonsecure_priority_shift = WB_DAT_IN[CTRL_NONSECURE_PRIORITY_SHIFT_BIT];
        end

        // ------------------------------------------------------------------
        // Read data
        // ------------------------------------------------------------------
        // Captured in the work cycle, so a read sees the arrays as they
        // stood before any write of the same cycle.
        if (q.busy) begin
            d.rdata = WORD_RST;
            if (hit_en_set || hit_en_clr) begin
                d.rdata = word_get(q.enable & vis, grp_word);
            end else if (hit_pend_set || hit_pend_clr) begin
                d.rdata = word_get(q.pending & vis, grp_word);
            end else if (hit_active) begin
                d.rdata = word_get(q.active & vis, grp_word);
            end else if (hit_target && SEC_IMPL && !nonsec) begin
                d.rdata = word_get(q.target, grp_word);
            end else if (prio_in_range) begin
                d.rdata = pif.ra_data & lane_mask(lane_vis);
            end else if (hit_ctrl && SEC_IMPL && !nonsec) begin
                d.rdata[CTRL_NONSECURE_PRIORITY_SHIFT_BIT] = q.nonsecure_priority_shift;
            end
        end

        // ------------------------------------------------------------------
        // Arbiter sweep
        // ------------------------------------------------------------------
        // One interrupt is examined per cycle, so a full sweep takes 64.
        d.scan_idx = q.scan_idx + 6'h01;
        d.eval_idx = q.scan_idx;
        d.eval_vld = 1'b1;
        if (q.eval_vld) begin
            if (q.eval_idx == '0) begin
                b_vld = 1'b0;
            end
            cand_raw = pif.rb_data[8*q.eval_idx[1:0] +: 8];
            cand_eff = eff_prio(cand_raw, q.target[q.eval_idx], q.nonsecure_priority_shift);
            // Only enabled pending interrupts compete.
            cand_ok  = q.pending[q.eval_idx] && q.enable[q.eval_idx];
            // Strictly lower wins, so ties go to the lower number.
            if (cand_ok && (!b_vld || cand_eff < b_prio)) begin
                b_vld  = 1'b1;
                b_id   = q.eval_idx;
                b_prio = cand_eff;
            end
            d.best_vld  = b_vld;
            d.best_id   = b_id;
            d.best_prio = b_prio;
        end

        // ------------------------------------------------------------------
        // Offer to the core
        // ------------------------------------------------------------------
        // An offer whose interrupt has lost its pending or enable state is
        // withdrawn at once, so a stale sweep result can never make the core
        // take a disabled or already cleared interrupt.
        if (take_hit || !(pend_n[q.req_id] && d.enable[q.req_id])) begin
            d.req = 1'b0;
        end
        if (q.eval_vld && q.eval_idx == LAST_IRQ) begin
            d.req      = b_vld && pend_n[b_id] && d.enable[b_id]
                      && !(TAKE_IN && TAKE_ID_IN == b_id);
            d.req_id   = b_id;
            d.req_prio = b_prio;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign WB_ACK_OUT   = q.ack;
    assign WB_DAT_OUT   = q.rdata;
    assign IRQ_REQ_OUT  = q.req;
    assign IRQ_ID_OUT   = q.req_id;
    assign IRQ_PRIO_OUT = q.req_prio;

endmodule
`default_nettype wire

// *** verif/ispb_bank_assertions.sv ***
// Port-level checks for the interrupt bank.
`timescale 1ns/100ps
`default_nettype none
module ispb_bank_assertions
    import ispb_pkg::*;
(
    // Clock and reset
    input wire logic            CLOCK_IN,
    input wire logic            SRST_IN,
    // Wishbone slave
    input wire logic            WB_CYC_IN,
    input wire logic            WB_STB_IN,
    input wire logic            WB_WE_IN,
    input wire logic [ADR_W-1:0] WB_ADR_IN,
    input wire logic            WB_NONSEC_IN,
    input wire logic            WB_ACK_OUT,
    input wire logic [31:0]     WB_DAT_OUT,
    // Core side
    input wire logic            TAKE_IN,
    input wire logic [ID_W-1:0] TAKE_ID_IN,
    input wire logic            IRQ_REQ_OUT,
    input wire logic [ID_W-1:0] IRQ_ID_OUT,
    input wire logic [7:0]      IRQ_PRIO_OUT
);
    wire logic       rd_ack = WB_ACK_OUT && !WB_WE_IN;
    wire logic [4:0] blk    = WB_ADR_IN[11:7];
    wire logic       in_pr  = WB_ADR_IN >= REG_PRIO && WB_ADR_IN <= REG_PRIO_END;

    default clocking dcb @(posedge CLOCK_IN);
    endclocking
    default disable iff (SRST_IN);

    a_ack_after_two: assert property ($rose(WB_CYC_IN && WB_STB_IN) |->
        !WB_ACK_OUT ##1 !WB_ACK_OUT ##1 WB_ACK_OUT) else $error("ack off its slot");
    a_ack_one_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack too long");
    a_reset_quiet: assert property (disable iff (1'b0) SRST_IN |=>
        !WB_ACK_OUT && !IRQ_REQ_OUT && WB_DAT_OUT == 32'h0) else $error("busy after reset");
    a_target_ns_zero: assert property (rd_ack && WB_NONSEC_IN && blk == 5'h07 |->
        WB_DAT_OUT == 32'h0) else $error("target word seen non-secure");
    a_beyond_zero: assert property (rd_ack && blk == 5'h02 && WB_ADR_IN[6:3] != 4'h0 |->
        WB_DAT_OUT == 32'h0) else $error("enable beyond count set");
    a_prio_low_zero: assert property (rd_ack && in_pr |->
        (WB_DAT_OUT & {4{~PRIO_MASK}}) == 32'h0) else $error("low priority bits set");
    a_offer_low_zero: assert property (IRQ_REQ_OUT |-> IRQ_PRIO_OUT[3:0] == 4'h0)
        else $error("offered priority low bits set");
    a_take_drops_req: assert property (TAKE_IN && IRQ_REQ_OUT && TAKE_ID_IN == IRQ_ID_OUT
        |=> !IRQ_REQ_OUT) else $error("offer held after take");
endmodule

bind ispb_bank ispb_bank_assertions u_ispb_bank_assertions (
    .CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_NONSEC_IN(WB_NONSEC_IN),
    .WB_ACK_OUT(WB_ACK_OUT), .WB_DAT_OUT(WB_DAT_OUT), .TAKE_IN(TAKE_IN),
    .TAKE_ID_IN(TAKE_ID_IN), .IRQ_REQ_OUT(IRQ_REQ_OUT), .IRQ_ID_OUT(IRQ_ID_OUT),
    .IRQ_PRIO_OUT(IRQ_PRIO_OUT));
`default_nettype wire

// *** verif/ispb_core_model.sv ***
// Behavioural processor core that takes offered interrupts.
`timescale 1ns/100ps
`default_nettype none
module ispb_core_model
    import ispb_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_in,
    input  wire logic            srst_in,
    // Bench control and offer
    input  wire logic            en_in,
    input  wire logic [7:0]      lat_in,
    input  wire logic            req_in,
    input  wire logic [ID_W-1:0] id_in,
    // Handler entry and exit
    output logic                 take_out,
    output logic [ID_W-1:0]      take_id_out,
    output logic                 done_out,
    output logic [ID_W-1:0]      done_id_out
);
    logic [7:0]      cnt;
    logic            busy;
    logic [ID_W-1:0] cur;

    // Id lines toggle between pulses so a stale id never passes for a live one.
    always @(posedge clk_in) begin
        take_out <= 1'b0;
        done_out <= 1'b0;
        take_id_out <= ~take_id_out;
        done_id_out <= ~done_id_out;
        cnt <= cnt + 8'h1;
        if (srst_in) begin
            busy <= 1'b0;
            cnt <= 8'h0;
            take_id_out <= '0;
            done_id_out <= '0;
        end else if (!busy && !(req_in && en_in)) begin
            cnt <= 8'h0;
        end else if (!busy && cnt >= lat_in) begin
            take_out <= 1'b1;
            take_id_out <= id_in;
            cur <= id_in;
            busy <= 1'b1;
            cnt <= 8'h0;
        end else if (busy && cnt == 8'hc8) begin
            done_out <= 1'b1;
            done_id_out <= cur;
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verif/ispb_bank_tb.sv ***
// Self-checking bench for the interrupt state and priority bank.
`timescale 1ns/100ps
`default_nettype none
module ispb_bank_tb import ispb_pkg::*; ;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               cyc = 1'b0;
    logic               stb = 1'b0;
    logic               we = 1'b0;
    logic               ns = 1'b0;
    logic               core_en = 1'b0;
    logic [ADR_W-1:0]   adr = '0;
    logic [3:0]         sel = '0;
    logic [31:0]        wdat = '0;
    logic [NUM_IRQ-1:0] lines = '0;
    logic [31:0]        rdat, dout;
    logic [31:0]        seed = 32'h6024;
    logic               ack, req, take, done;
    logic [ID_W-1:0]    oid, tid, did;
    logic [7:0]         oprio;
    logic [7:0]         pr [NUM_IRQ] = '{default: 8'h0};
    int                 failures = 0;
    int                 num_checks = 0;

    always #5 clk = ~clk;

    ispb_bank u_ispb_bank (
        .CLOCK_IN(clk), .SRST_IN(srst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_NONSEC_IN(ns),
        .WB_ACK_OUT(ack), .WB_DAT_OUT(dout), .IRQ_LINES_IN(lines), .TAKE_IN(take),
        .TAKE_ID_IN(tid), .DONE_IN(done), .DONE_ID_IN(did), .IRQ_REQ_OUT(req),
        .IRQ_ID_OUT(oid), .IRQ_PRIO_OUT(oprio));

    ispb_core_model u_ispb_core_model (
        .clk_in(clk), .srst_in(srst), .en_in(core_en), .lat_in(8'h03), .req_in(req),
        .id_in(oid), .take_out(take), .take_id_out(tid), .done_out(done), .done_id_out(did));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] eff(input logic [7:0] p, input logic sh);
        return sh ? (8'h80 | (p >> 1)) : p;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [3:0] s,
                      input logic [31:0] d, input logic n);
        int k;
        k = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat, ns} <= {2'b11, w, a, s, d, n};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            failures++;
            $display("ERROR %0t: bus cycle never acknowledged", $time);
        end
        rdat = dout;
        {cyc, stb, wdat} <= {2'b00, ~d};
    endtask

    task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d, input logic n);
        wb(1'b1, a, 4'hf, d, n);
    endtask

    task automatic rd(input logic [ADR_W-1:0] a, input logic n, input logic [31:0] e);
        wb(1'b0, a, 4'hf, 32'h0, n);
        chk(rdat, e);
    endtask

    task automatic pw(input int w, input logic [3:0] s, input logic [31:0] d);
        wb(1'b1, REG_PRIO + 12'(4 * w), s, d, 1'b0);
        for (int l = 0; l < 4; l++)
            if (s[l]) pr[4 * w + l] = d[8 * l +: 8] & PRIO_MASK;
    endtask

    task automatic wait_hi(input bit pick_done);
        int k;
        k = 0;
        while ((pick_done ? done : take) !== 1'b1 && k < 400) begin
            @(posedge clk);
            k++;
        end
        chk(32'(pick_done ? done : take), 32'h1);
    endtask

    task automatic wait_offer(input logic [ID_W-1:0] id, input logic [7:0] p);
        int k;
        k = 0;
        while (!(req === 1'b1 && oid === id && oprio === p) && k < 300) begin
            @(posedge clk);
            k++;
        end
        chk(32'({req, oid, oprio}), 32'({1'b1, id, p}));
    endtask

    initial begin
        #300000;
        failures++;
        give_verdict();
    end

    initial begin
        logic [31:0] r, m, t;
        logic [3:0]  s;
        int          a, b, w;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(REG_EN_SET + 12'(128 * i + 4 * (i % 2)), 1'b0, WORD_RST);
        r = xs();
        m = xs();
        wr(REG_EN_SET, r, 0);
        rd(REG_EN_SET, 0, r);
        wr(REG_EN_CLR, m, 0);
        wr(REG_EN_SET, 32'h0, 0);
        rd(REG_EN_CLR, 0, r & ~m);
        wr(REG_EN_SET + 12'h8, '1, 0);
        rd(REG_EN_SET + 12'h8, 0, 32'h0);
        wr(REG_PEND_SET + 12'h4, r, 0);
        wr(REG_PEND_SET + 12'h4, m, 0);
        rd(REG_PEND_CLR + 12'h4, 0, r | m);
        t = xs();
        wr(REG_PEND_CLR + 12'h4, t, 0);
        rd(REG_PEND_SET + 12'h4, 0, (r | m) & ~t);
        wr(REG_PEND_CLR + 12'h4, '1, 0);
        wr(REG_EN_CLR, '1, 0);
        wr(REG_TARGET, t, 0);
        wr(REG_TARGET, 32'h0, 1);
        rd(REG_TARGET, 0, t);
        rd(REG_TARGET, 1, 32'h0);
        wr(REG_EN_SET, '1, 1);
        rd(REG_EN_SET, 1, t);
        rd(REG_EN_SET, 0, t);
        wr(REG_EN_CLR, '1, 0);
        wr(REG_TARGET, 32'h0, 0);
        wr(REG_PRIO + 12'h40, '1, 0);
        rd(REG_PRIO + 12'h40, 0, 32'h0);
        rd(12'h600, 0, 32'h0);
        for (int i = 0; i < 12; i++) begin
            w = int'(xs() % 16);
            s = 4'(xs());
            if (s == 4'h0)
                s = 4'h3;
            pw(w, s, xs());
            rd(REG_PRIO + 12'(4 * w), 0, {pr[4*w+3], pr[4*w+2], pr[4*w+1], pr[4*w]});
        end
        a = int'(xs() % 32);
        b = (a + 1 + int'(xs() % 31)) % 32;
        wr(REG_PEND_CLR, '1, 0);
        pw(a / 4, 4'(1 << (a % 4)), 32'h40 << (8 * (a % 4)));
        pw(b / 4, 4'(1 << (b % 4)), 32'h20 << (8 * (b % 4)));
        wr(REG_EN_SET, 32'h1 << a, 0);
        lines[a] <= 1'b1;
        lines[b] <= 1'b1;
        wait_offer(6'(a), 8'h40);
        rd(REG_PEND_SET, 0, (32'h1 << a) | (32'h1 << b));
        repeat (140) @(posedge clk);
        chk(32'({req, oid}), 32'({1'b1, 6'(a)}));
        wr(REG_EN_SET, 32'h1 << b, 0);
        wait_offer(6'(b), 8'h20);
        lines <= '0;
        core_en <= 1'b1;
        wait_hi(1'b0);
        core_en <= 1'b0;
        rd(REG_ACTIVE, 0, 32'h1 << b);
        wr(REG_PEND_SET, 32'h1 << b, 0);
        wr(REG_PEND_CLR, 32'h1 << b, 0);
        rd(REG_ACTIVE, 0, 32'h1 << b);
        rd(REG_PEND_SET, 0, 32'h1 << a);
        wait_hi(1'b1);
        rd(REG_ACTIVE, 0, 32'h0);
        wr(REG_CTRL, 32'h1, 0);
        wr(REG_TARGET, 32'h1 << a, 0);
        wait_offer(6'(a), eff(8'h40, 1'b1));
        give_verdict();
    end
endmodule
`default_nettype wire
